// ---- hw/bfds_top.sv ----
// Behaviour
// RQ1: overtemp trip sets fault state, flag low
// RQ2: overtemp clears only below recovery level
// RQ3: overtemp never disables gates, non-latching
// RQ4: regulator undervoltage sets fault, disables gates
// RQ5: regulator undervoltage clears itself on rising
// RQ6: regulator undervoltage active from power-up
// RQ7: low bootstrap withholds high, charges via low
// RQ8: bootstrap watched while high side on
// RQ9: charge timeout latches bootstrap fault, disables
// RQ10: bootstrap fault cleared only by reset low or logic undervoltage
// RQ11: logic undervoltage sets fault, disables gates
// RQ12: logic undervoltage clears all other faults
// RQ13: logic undervoltage from power-up, non-latching
// RQ14: disabled means all gate outputs low
// RQ15: one dead time for both phases
// RQ16: dead time also after charge cycle
// RQ17: pin strapped high selects six microseconds
// RQ18: pin strapped low gives zero dead
// RQ19: controller supplies dead time when disabled
// RQ20: dead time only within interval after off
// RQ21: controller brakes with both lows or highs
// RQ22: both inputs asserted drives low side only
// RQ23: reset input low idles gates, sleeps
// RQ24: charge cycle lasts at least seven microseconds
// RQ25: charge timeout about two hundred microseconds
// RQ26: fault flag low when any fault active
// RQ27: comparator inputs synchronised before use
`timescale 1ns/1ps
`default_nettype none
module bfds_top
    import bfds_pkg::*;
#(
    parameter int charge_timeout_cyc = bfds_pkg::bfds_charge_timeout_cyc
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic phase_a_high_cmd,
    input wire logic phase_a_low_cmd,
    input wire logic phase_b_high_cmd,
    input wire logic phase_b_low_cmd,
    input wire logic reset_n_pin,
    input wire logic overtemp_trip,
    input wire logic overtemp_recovered,
    input wire logic regulator_below_falling,
    input wire logic regulator_above_rising,
    input wire logic logic_below_falling,
    input wire logic logic_above_rising,
    input wire logic [1:0] boot_ok,
    input wire logic [1:0] boot_low,
    input wire logic dead_pin_high,
    input wire logic dead_pin_low,
    output logic [1:0] high_side_gate_out,
    output logic [1:0] low_side_gate_out,
    output logic fault_n
);
    import bfds_pkg::*;

    localparam int n_sync = 17;
    logic [n_sync-1:0] sync_in;
    logic [n_sync-1:0] sync_a;
    logic [n_sync-1:0] sync_b;
    logic [3:0] cmd_s;
    logic rst_pin_s;
    logic ot_trip_s, ot_rec_s, reg_fall_s, reg_rise_s, logic_fall_s, logic_rise_s;
    logic [1:0] boot_ok_s;
    logic [1:0] boot_low_s;
    logic dead_hi_s, dead_lo_s;
    logic ot_fault;
    logic reg_uv;
    logic logic_uv;
    logic [1:0] boot_fault;
    logic disable_all;
    logic clear_latch;
    logic [31:0] ctrl;
    logic [bfds_cnt_w-1:0] dead_reg;
    logic [bfds_cnt_w-1:0] dead_cyc;
    logic [1:0] dead_sel;
    logic [31:0] status;
    logic aw_held, w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    ////////////////////////////////////////////////////////////////
    // two-stage synchronisers for all pin-level inputs
    assign sync_in = {dead_pin_low, dead_pin_high, boot_low, boot_ok, logic_above_rising, logic_below_falling,
                      regulator_above_rising, regulator_below_falling, overtemp_recovered, overtemp_trip,
                      reset_n_pin, phase_b_low_cmd, phase_b_high_cmd, phase_a_low_cmd, phase_a_high_cmd};

    genvar gi;
    generate
        for (gi = 0; gi < n_sync; gi++) begin : g_sync
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    sync_a[gi] <= 1'b0;
                    sync_b[gi] <= 1'b0;
                end else begin
                    sync_a[gi] <= sync_in[gi]; // RQ27
                    sync_b[gi] <= sync_a[gi];
                end
            end
        end
    endgenerate

    assign cmd_s = sync_b[3:0];
    assign rst_pin_s = sync_b[4];
    assign ot_trip_s = sync_b[5];
    assign ot_rec_s = sync_b[6];
    assign reg_fall_s = sync_b[7];
    assign reg_rise_s = sync_b[8];
    assign logic_fall_s = sync_b[9];
    assign logic_rise_s = sync_b[10];
    assign boot_ok_s = sync_b[12:11];
    assign boot_low_s = sync_b[14:13];
    assign dead_hi_s = sync_b[15];
    assign dead_lo_s = sync_b[16];

    ////////////////////////////////////////////////////////////////
    // fault states; a fresh logic undervoltage wipes the others
    logic logic_enter;

    assign logic_enter = logic_fall_s && !logic_uv;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            logic_uv <= 1'b1; // RQ13
        end else if (logic_fall_s) begin
            logic_uv <= 1'b1; // RQ11
        end else if (logic_rise_s) begin
            logic_uv <= 1'b0; // RQ13
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_uv <= 1'b1; // RQ6
        end else if (logic_enter) begin
            reg_uv <= 1'b0; // RQ12
        end else if (reg_fall_s) begin
            reg_uv <= 1'b1; // RQ4
        end else if (reg_rise_s) begin
            reg_uv <= 1'b0; // RQ5
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ot_fault <= 1'b0;
        end else if (logic_enter) begin
            ot_fault <= 1'b0; // RQ12
        end else if (ot_trip_s) begin
            ot_fault <= 1'b1; // RQ1
        end else if (ot_rec_s) begin
            ot_fault <= 1'b0; // RQ2
        end
    end

    // overtemp only reports, so it stays out of disable
    assign disable_all = reg_uv || logic_uv || (|boot_fault) || !rst_pin_s; // RQ3 RQ14 RQ23
    assign clear_latch = !rst_pin_s || logic_enter; // RQ10 RQ12

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fault_n <= 1'b0;
        end else begin
            fault_n <= !(ot_fault || reg_uv || logic_uv || (|boot_fault)); // RQ26
        end
    end

    ////////////////////////////////////////////////////////////////
    // no resistor reading exists in logic,
    // so the register stands in for the resistor setting
    assign dead_sel = ctrl[1:0];

    always_comb begin
        if (dead_sel == bfds_dead_max) begin
            dead_cyc = bfds_cnt_w'(bfds_dead_max_cyc);
        end else if (dead_sel == bfds_dead_none) begin
            dead_cyc = '0;
        end else if (dead_sel == bfds_dead_reg) begin
            dead_cyc = dead_reg;
        end else if (dead_hi_s) begin
            dead_cyc = bfds_cnt_w'(bfds_dead_max_cyc); // RQ17
        end else if (dead_lo_s) begin
            dead_cyc = '0; // RQ18
        end else begin
            dead_cyc = dead_reg;
        end
    end

    ////////////////////////////////////////////////////////////////
    // index 0 is phase a
    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_phase
            bfds_phase #(
                .charge_timeout_cyc(charge_timeout_cyc)
            ) bfds_phase_inst (
                .aclk(aclk),
                .aresetn(aresetn),
                .high_cmd(cmd_s[2*gp]),
                .low_cmd(cmd_s[2*gp+1]),
                .boot_ok(boot_ok_s[gp]),
                .boot_low(boot_low_s[gp]),
                .disable_all(disable_all),
                .clear_latch(clear_latch),
                .dead_cyc(dead_cyc), // RQ15
                .high_side_gate_out(high_side_gate_out[gp]),
                .low_side_gate_out(low_side_gate_out[gp]),
                .boot_fault(boot_fault[gp])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    always_comb begin
        status = 32'h0000_0000;
        status[bfds_st_ot] = ot_fault;
        status[bfds_st_reg_uv] = reg_uv;
        status[bfds_st_boot_uv] = |boot_fault;
        status[bfds_st_logic_uv] = logic_uv;
        status[bfds_st_fault] = !fault_n;
        status[bfds_st_gate +: 4] = {low_side_gate_out, high_side_gate_out};
    end

    ////////////////////////////////////////////////////////////////
    // write side: address and data taken in either order
    logic aw_take;
    logic w_take;
    logic write_now;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] wr_mask;

    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign write_now = (aw_held || aw_take) && (w_held || w_take) && !s_axi_bvalid;
    assign wr_addr = aw_held ? aw_addr : s_axi_awaddr[3:0];
    assign wr_data = w_held ? w_data : s_axi_wdata;
    assign wr_strb = w_held ? w_strb : s_axi_wstrb;
    assign wr_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr[3:0];
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (write_now) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= bfds_resp_okay;
        end else if (write_now) begin
            s_axi_bvalid <= 1'b1;
            if (wr_addr == bfds_off_ctrl || wr_addr == bfds_off_status || wr_addr == bfds_off_dead) begin
                s_axi_bresp <= bfds_resp_okay;
            end else begin
                s_axi_bresp <= bfds_resp_slverr;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= bfds_ctrl_reset;
        end else if (write_now && wr_addr == bfds_off_ctrl) begin
            ctrl <= (ctrl & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dead_reg <= bfds_dead_reg_reset;
        end else if (write_now && wr_addr == bfds_off_dead) begin
            dead_reg <= (dead_reg & ~wr_mask[15:0]) | (wr_data[15:0] & wr_mask[15:0]);
        end
    end

    ////////////////////////////////////////////////////////////////
    // upper address bits are not decoded, so offsets alias
    logic ar_take;
    logic [3:0] rd_addr;

    assign s_axi_arready = !s_axi_rvalid;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_addr = s_axi_araddr[3:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= bfds_resp_okay;
        end else if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= bfds_resp_okay;
            if (rd_addr == bfds_off_ctrl) begin
                s_axi_rdata <= ctrl;
            end else if (rd_addr == bfds_off_status) begin
                s_axi_rdata <= status;
            end else if (rd_addr == bfds_off_dead) begin
                s_axi_rdata <= {16'h0000, dead_reg};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= bfds_resp_slverr;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ---- pkg/bfds_pkg.sv ----
package bfds_pkg;
    // bus
    localparam logic [31:0] bfds_axi_addr_mask = 32'h0000_000F;
    localparam logic [3:0] bfds_off_ctrl = 4'h0;
    localparam logic [3:0] bfds_off_status = 4'h4;
    localparam logic [3:0] bfds_off_dead = 4'h8;
    localparam logic [1:0] bfds_resp_okay = 2'h0;
    localparam logic [1:0] bfds_resp_slverr = 2'h2;
    // reset values
    localparam logic [31:0] bfds_ctrl_reset = 32'h0000_0000;
    // dead-time select encodings held in ctrl[1:0]
    localparam logic [1:0] bfds_dead_pin = 2'h0;
    localparam logic [1:0] bfds_dead_max = 2'h1;
    localparam logic [1:0] bfds_dead_none = 2'h2;
    localparam logic [1:0] bfds_dead_reg = 2'h3;
    // status bit positions
    localparam int bfds_st_ot = 0;
    localparam int bfds_st_reg_uv = 1;
    localparam int bfds_st_boot_uv = 2;
    localparam int bfds_st_logic_uv = 3;
    localparam int bfds_st_fault = 4;
    localparam int bfds_st_gate = 8;
    // timing
    localparam int bfds_clk_mhz = 100;
    localparam int bfds_dead_max_ns = 6000;
    localparam int bfds_charge_min_ns = 7000;
    localparam int bfds_charge_timeout_ns = 200000;
    localparam int bfds_dead_max_cyc = (bfds_dead_max_ns * bfds_clk_mhz + 999) / 1000;
    localparam int bfds_charge_min_cyc = (bfds_charge_min_ns * bfds_clk_mhz + 999) / 1000;
    localparam int bfds_charge_timeout_cyc = bfds_charge_timeout_ns * bfds_clk_mhz / 1000;
    localparam int bfds_cnt_w = 16;
    localparam logic [bfds_cnt_w-1:0] bfds_dead_reg_reset = 16'h0064;
    typedef enum logic [1:0] {bfds_ph_idle, bfds_ph_charge, bfds_ph_fault} bfds_ph_type;
endpackage

// ---- hw/bfds_phase.sv ----
`timescale 1ns/1ps
`default_nettype none
module bfds_phase
    import bfds_pkg::*;
#(
    parameter int charge_timeout_cyc = bfds_charge_timeout_cyc
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic high_cmd,
    input wire logic low_cmd,
    input wire logic boot_ok,
    input wire logic boot_low,
    input wire logic disable_all,
    input wire logic clear_latch,
    input wire logic [bfds_cnt_w-1:0] dead_cyc,
    output logic high_side_gate_out,
    output logic low_side_gate_out,
    output logic boot_fault
);
    bfds_ph_type state;
    logic [17:0] charge_cnt;
    logic [bfds_cnt_w-1:0] dead_cnt;
    logic want_high;
    logic want_low;
    logic last_side;
    logic charge_done;

    ////////////////////////////////////////////////////////////////
    // input lockout: both asserted means low only
    assign want_low = low_cmd; // RQ22
    assign want_high = high_cmd && !low_cmd; // RQ22
    assign charge_done = boot_ok && (charge_cnt >= 18'(bfds_charge_min_cyc)); // RQ24

    ////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn || clear_latch) begin
            state <= bfds_ph_idle;
            charge_cnt <= '0;
        end else begin
            case (state)
                bfds_ph_idle: begin
                    charge_cnt <= '0;
                    if (!disable_all && want_high && (!boot_ok || (high_side_gate_out && boot_low))) begin // RQ7 RQ8
                        state <= bfds_ph_charge;
                    end
                end
                bfds_ph_charge: begin
                    charge_cnt <= charge_cnt + 18'h00001;
                    if (disable_all) begin
                        state <= bfds_ph_idle;
                    end else if (charge_done) begin
                        state <= bfds_ph_idle;
                    end else if (charge_cnt >= 18'(charge_timeout_cyc)) begin // RQ9 RQ25
                        state <= bfds_ph_fault;
                    end
                end
                bfds_ph_fault: begin
                    charge_cnt <= '0;
                end
                default: begin
                    state <= bfds_ph_idle;
                end
            endcase
        end
    end
    assign boot_fault = (state == bfds_ph_fault);

    ////////////////////////////////////////////////////////////////
    // dead time runs only from a turn-off; a turn-on after it expires is immediate
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            high_side_gate_out <= 1'b0;
            low_side_gate_out <= 1'b0;
            dead_cnt <= '0;
            last_side <= 1'b0;
        end else if (disable_all) begin
            high_side_gate_out <= 1'b0; // RQ14
            low_side_gate_out <= 1'b0;
            dead_cnt <= '0;
        end else begin
            if (dead_cnt != '0) begin
                dead_cnt <= dead_cnt - 16'h0001;
            end
            if (state == bfds_ph_charge || want_low) begin
                high_side_gate_out <= 1'b0;
                if (high_side_gate_out) begin
                    dead_cnt <= dead_cyc;
                    last_side <= 1'b1;
                end else if (dead_cnt == '0 || !last_side) begin // RQ16
                    low_side_gate_out <= 1'b1;
                end
            end else if (want_high && boot_ok) begin // RQ7 RQ20
                low_side_gate_out <= 1'b0;
                if (low_side_gate_out) begin
                    dead_cnt <= dead_cyc;
                    last_side <= 1'b0;
                end else if (dead_cnt == '0 || last_side) begin
                    high_side_gate_out <= 1'b1;
                end
            end else begin
                if (high_side_gate_out) begin
                    dead_cnt <= dead_cyc;
                    last_side <= 1'b1;
                end
                if (low_side_gate_out) begin
                    dead_cnt <= dead_cyc;
                    last_side <= 1'b0;
                end
                high_side_gate_out <= 1'b0;
                low_side_gate_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- testbench/bfds_top_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module bfds_top_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic phase_a_high_cmd,
    input wire logic reset_n_pin,
    input wire logic overtemp_trip,
    input wire logic regulator_below_falling,
    input wire logic logic_below_falling,
    input wire logic [1:0] boot_ok,
    input wire logic [1:0] high_side_gate_out,
    input wire logic [1:0] low_side_gate_out,
    input wire logic fault_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // window of 8 leaves room for comparator synchronisers
    a_gate_exclusive: assert property ((high_side_gate_out & low_side_gate_out) == 2'h0)
        else $error("high and low gate on together");
    a_reg_uv_off: assert property ($rose(regulator_below_falling) |-> ##[1:8]
        ({fault_n, high_side_gate_out, low_side_gate_out} == 5'h00)) else $error("regulator fault not seen");
    a_logic_uv_off: assert property ($rose(logic_below_falling) |-> ##[1:8]
        ({fault_n, high_side_gate_out, low_side_gate_out} == 5'h00)) else $error("logic fault not seen");
    a_uv_hold_off: assert property (regulator_below_falling [*8] |->
        ({high_side_gate_out, low_side_gate_out} == 4'h0)) else $error("gates on in undervoltage");
    a_ot_flag_low: assert property ($rose(overtemp_trip) |-> ##[1:8] !fault_n)
        else $error("overtemp flag missing");
    a_sleep_off: assert property ((!reset_n_pin) [*4] |->
        ({high_side_gate_out, low_side_gate_out} == 4'h0)) else $error("gates on in sleep");
    a_high_needs_boot: assert property ($rose(high_side_gate_out[0]) |-> $past(boot_ok[0], 3))
        else $error("high side on without bootstrap");
    a_high_needs_cmd: assert property ($rose(high_side_gate_out[0]) |-> $past(phase_a_high_cmd, 3))
        else $error("high side on without command");
    c_flag_release: cover property ($rose(fault_n));
    c_brake_low: cover property (low_side_gate_out == 2'h3);
    c_brake_high: cover property (high_side_gate_out == 2'h3);
endmodule
bind bfds_top bfds_top_asserts bfds_top_asserts_inst (.aclk, .aresetn, .phase_a_high_cmd, .reset_n_pin,
    .overtemp_trip, .regulator_below_falling, .logic_below_falling, .boot_ok, .high_side_gate_out,
    .low_side_gate_out, .fault_n);
`default_nettype wire

// ---- testbench/bfds_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module bfds_ctrl_model (
    input wire logic aclk,
    input wire logic [3:0] want,
    input wire logic [15:0] gap,
    output logic [3:0] cmd
);
    logic [3:0] held = 4'h0;
    logic [15:0] wait_cnt = 16'h0000;
    initial cmd = 4'h0;
    // turn-offs go at once, turn-ons wait out the gap
    always @(posedge aclk) begin
        if (want != held) begin
            held <= want;
            cmd <= cmd & want;
            wait_cnt <= gap;
        end else if (wait_cnt != 16'h0000) begin
            wait_cnt <= wait_cnt - 16'h0001;
        end else begin
            cmd <= want;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/tb_bfds_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_bfds_top;
    import bfds_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, sleep_n = 1;
    logic awr, wr, bv, arr, rv, fault_n, ot_trip = 0, ot_rec = 0, reg_lo = 0, reg_hi = 0;
    logic vdd_lo = 0, vdd_hi = 0, pin_hi = 1, pin_lo = 0;
    logic [31:0] awa = 0, wd = 0, ara = 0, rd, d;
    logic [1:0] bresp, rresp, r, hs, ls, boot_ok = 2'h3, boot_low = 2'h0;
    logic [3:0] want = 0, cmd;
    logic [15:0] gap = 0;
    int miscompares = 0, check_count = 0, seed = 32'h55aa;
    bfds_top #(.charge_timeout_cyc(2000)) bfds_top_inst (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
        .s_axi_rvalid(rv), .s_axi_rready(rrdy), .phase_a_high_cmd(cmd[3]), .phase_a_low_cmd(cmd[2]),
        .phase_b_high_cmd(cmd[1]), .phase_b_low_cmd(cmd[0]), .reset_n_pin(sleep_n), .overtemp_trip(ot_trip),
        .overtemp_recovered(ot_rec), .regulator_below_falling(reg_lo), .regulator_above_rising(reg_hi),
        .logic_below_falling(vdd_lo), .logic_above_rising(vdd_hi), .boot_ok(boot_ok), .boot_low(boot_low),
        .dead_pin_high(pin_hi), .dead_pin_low(pin_lo), .high_side_gate_out(hs), .low_side_gate_out(ls),
        .fault_n(fault_n));
    bfds_ctrl_model bfds_ctrl_model_inst (.aclk(aclk), .want(want), .gap(gap), .cmd(cmd));
    initial forever #5 aclk = ~aclk;
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("miscompares %0d check_count %0d", miscompares, check_count);
        if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic axw(input logic [31:0] a, input logic [31:0] v);
        logic hit_aw, hit_w, hit_b;
        @(posedge aclk);
        awa <= a;
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        // sample mid-cycle: same values as at the next rising edge
        do begin
            @(negedge aclk);
            hit_aw = (awv && awr) === 1'b1;
            hit_w = (wv && wr) === 1'b1;
            hit_b = bv === 1'b1;
            r = bresp;
            @(posedge aclk);
            if (hit_aw) awv <= 1'b0;
            if (hit_w) wv <= 1'b0;
        end while (!hit_b);
        brdy <= 1'b0;
        chk(r, bfds_resp_okay);
    endtask
    task automatic axr(input logic [31:0] a);
        logic hit_ar, hit_r;
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(negedge aclk);
            hit_ar = (arv && arr) === 1'b1;
            hit_r = rv === 1'b1;
            d = rd;
            r = rresp;
            @(posedge aclk);
            if (hit_ar) arv <= 1'b0;
        end while (!hit_r);
        rrdy <= 1'b0;
    endtask
    // far: phase idles first, so no dead time is owed
    task automatic dead(input int ph, input int exp, input bit far);
        int n;
        n = 0;
        want <= 4'b0100 >> (2 * ph);
        cyc(700);
        if (far) want <= 4'h0;
        if (far) cyc(700);
        want <= 4'b1000 >> (2 * ph);
        cyc(1);
        while (hs[ph] !== 1'b1 && n < 1000) begin
            cyc(1);
            n++;
        end
        chk(n >= exp && n <= exp + 12, 1);
    endtask
    initial begin
        cyc(20);
        aresetn <= 1'b1;
        cyc(4);
        chk({fault_n, hs, ls}, 0);
        {reg_hi, vdd_hi} <= 2'b11;
        cyc(10);
        chk(fault_n, 1);
        axr(32'h0000_000C);
        chk(r, bfds_resp_slverr);
        axr(bfds_off_ctrl);
        chk(d, bfds_ctrl_reset);
        axw(bfds_off_ctrl, {30'h0, bfds_dead_pin});
        for (int ph = 0; ph < 2; ph++) dead(ph, bfds_dead_max_cyc, 0);
        dead(0, 0, 1);
        {pin_hi, pin_lo, gap} <= {2'b01, 16'd20};
        dead(0, 20, 0);
        for (int k = 0; k < 3; k++) begin
            want <= k == 0 ? 4'hC : (k == 1 ? 4'h5 : 4'hA);
            cyc(40);
            chk({hs, ls}, k == 0 ? 4'h1 : (k == 1 ? 4'h3 : 4'hC));
        end
        want <= 4'h8;
        cyc(40);
        ot_trip <= 1'b1;
        cyc(10);
        chk({fault_n, hs, ls}, 5'h04);
        ot_trip <= 1'b0;
        cyc(10);
        chk(fault_n, 0);
        ot_rec <= 1'b1;
        cyc(10);
        chk(fault_n, 1);
        {ot_rec, boot_ok, boot_low} <= 5'b0_10_01;
        cyc(30);
        chk({hs, ls}, 4'h1);
        cyc(2100);
        chk({fault_n, hs, ls}, 0);
        {boot_ok, boot_low} <= 4'b11_00;
        cyc(100);
        chk(fault_n, 0);
        axr(bfds_off_status);
        chk(d, (32'h1 << bfds_st_boot_uv) | (32'h1 << bfds_st_fault));
        sleep_n <= 1'b0;
        cyc(10);
        chk({hs, ls}, 0);
        sleep_n <= 1'b1;
        cyc(20);
        chk(fault_n, 1);
        want <= 4'h0;
        cyc(40);
        {want, boot_ok} <= 6'b1000_10;
        cyc(30);
        chk({hs, ls}, 4'h1);
        cyc(2100);
        boot_ok <= 2'h3;
        for (int k = 0; k < 2; k++) begin
            {reg_lo, vdd_lo, reg_hi, vdd_hi} <= k ? 4'b1001 : 4'b0110;
            cyc(10);
            chk({fault_n, hs, ls}, 0);
            {reg_lo, vdd_lo, reg_hi, vdd_hi} <= 4'b0011;
            cyc(10);
            chk(fault_n, 1);
        end
        for (int i = 0; i < 40; i++) begin
            want <= 4'($random(seed));
            cyc(1 + ($random(seed) & 63));
            chk(hs & ls, 0);
        end
        axw(bfds_off_dead, 32'h0000_0032);
        axr(bfds_off_dead);
        chk(d, 32'h0000_0032);
        axw(bfds_off_ctrl, {30'h0, bfds_dead_reg});
        dead(1, 50, 0);
        axw(bfds_off_ctrl, {30'h0, bfds_dead_max});
        dead(0, bfds_dead_max_cyc, 0);
        conclude();
    end
    // whole sequence needs about 13000 cycles
    initial begin
        cyc(40000);
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
